// *** tws_pkg.sv ***
// tws_pkg: constants, register map and encodings of the two-wire slave
// assumes a 100 MHz system clock and 32-bit AXI4-Lite register access
package tws_pkg;
  // clock rate and sda hold extension
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned HOLD_NS    = 50;
  localparam int unsigned HOLD_CYC_I = (HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [2:0]  HOLD_CYC   = 3'(HOLD_CYC_I);
  // register indexes, byte address is four times the index
  localparam logic [7:0]  IDX_OWN_ADDR = 8'h2A;
  localparam logic [7:0]  IDX_STATUS   = 8'h2B;
  localparam logic [7:0]  IDX_CTRL_B   = 8'h2C;
  localparam logic [7:0]  IDX_CTRL_A   = 8'h2D;
  localparam logic [7:0]  IDX_DATA     = 8'h2E;
  localparam logic [7:0]  IDX_NONE     = 8'hFF;
  // values after reset
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  // control a bit positions
  localparam int unsigned CA_HOLD = 7;
  localparam int unsigned CA_RSVD = 6;
  localparam int unsigned CA_DIE  = 5;
  localparam int unsigned CA_ASIE = 4;
  localparam int unsigned CA_EN   = 3;
  localparam int unsigned CA_SIE  = 2;
  localparam int unsigned CA_PME  = 1;
  localparam int unsigned CA_SME  = 0;
  // control b and status bit positions
  localparam int unsigned CB_AA   = 2;
  localparam int unsigned SR_DF   = 7;
  localparam int unsigned SR_ASF  = 6;
  localparam int unsigned SR_COLL = 3;
  localparam int unsigned SR_BERR = 2;
  // bit counts within a packet
  localparam logic [3:0]  BYTE_BITS = 4'h8;
  localparam logic [3:0]  ACK_BIT   = 4'h9;
  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // slave commands
  typedef enum logic [1:0] {
    CMD_NONE     = 2'b00,
    CMD_RSVD     = 2'b01,
    CMD_COMPLETE = 2'b10,
    CMD_RESPOND  = 2'b11
  } tws_cmd_t;
  // bit engine states
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ADDR      = 3'b001,
    ST_ADDR_HOLD = 3'b010,
    ST_ACK       = 3'b011,
    ST_RX        = 3'b100,
    ST_RX_HOLD   = 3'b101,
    ST_TX_HOLD   = 3'b110,
    ST_TX        = 3'b111
  } tws_state_t;
  // where the engine goes after an acknowledge bit
  typedef enum logic [1:0] {
    AFT_IDLE = 2'b00,
    AFT_RX   = 2'b01,
    AFT_TX   = 2'b10
  } tws_after_t;
endpackage

// *** tws_link_if.sv ***
// tws_link_if: bus line events and sda request between engine and line stage
// assumes both ends run on the same system clock
`timescale 1ns/100ps
`default_nettype none
interface tws_link_if;
  logic scl_rise;   // synchronised scl rising edge
  logic scl_fall;   // synchronised scl falling edge
  logic sda_lvl;    // synchronised sda level
  logic start_det;  // start or repeated start seen
  logic stop_det;   // stop seen
  logic hold_ext;   // add sda hold delay after scl fall
  logic sda_want;   // engine wants sda pulled low
  modport line   (output scl_rise, scl_fall, sda_lvl, start_det, stop_det,
                  input  hold_ext, sda_want);
  modport engine (input  scl_rise, scl_fall, sda_lvl, start_det, stop_det,
                  output hold_ext, sda_want);
endinterface
`default_nettype wire

// *** tws_line.sv ***
// tws_line: scl/sda synchronisers, edge and start/stop detection, sda drive
// assumes raw pins from outside the clock domain; sda_oe feeds the pin enable
`timescale 1ns/100ps
`default_nettype none
module tws_line
  import tws_pkg::*;
(
  // clock and reset
  input  wire logic    aclk,
  input  wire logic    aresetn,
  // raw bus lines
  input  wire logic    scl_in,
  input  wire logic    sda_in,
  // sda pull-down enable
  output logic         sda_oe,
  // engine side
  tws_link_if.line     lnk
);
  logic [1:0] scl_sync;   // scl two-flop synchroniser
  logic [1:0] sda_sync;   // sda two-flop synchroniser
  logic       scl_q;      // previous synchronised scl
  logic       sda_q;      // previous synchronised sda
  logic [2:0] hold_cnt;   // sda hold delay countdown
  wire        hold_load = lnk.scl_fall & lnk.hold_ext;

  // synchronisers, idle bus reads high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  // edges and bus conditions from the second stage only
  assign lnk.scl_rise  = scl_sync[1] & ~scl_q;
  assign lnk.scl_fall  = ~scl_sync[1] & scl_q;
  assign lnk.sda_lvl   = sda_sync[1];
  assign lnk.start_det = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign lnk.stop_det  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

  // sda changes only once the hold delay has run out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt <= 3'h0;
      sda_oe   <= 1'b0;
    end else begin
      if (hold_load) begin
        hold_cnt <= HOLD_CYC;
      end else if (hold_cnt != 3'h0) begin
        hold_cnt <= hold_cnt - 3'h1;
      end
      if (hold_cnt == 3'h0 && !hold_load) begin
        sda_oe <= lnk.sda_want;
      end
    end
  end
endmodule
`default_nettype wire

// *** tws_slave_top.sv ***
// tws_slave_top: byte-oriented two-wire slave with AXI4-Lite registers
// assumes open-drain pads resolved outside; irq_global_enable on aclk
//
// Summary of operation
// - separate data and address/stop flags
// - either flag set holds scl low
// - start, address byte, ack on match
// - matching or general call address sets flag
// - start directly followed by stop: bus error
// - direction flag takes received read/write bit
// - master read: ack then data flag
// - master write: ack then await data
// - lost high bit: collision, release, idle
// - stop sets flag, cause marked stop
// - each received byte sets data flag
// - transmit data byte, nack ends sending
// - optional 50 ns sda hold after fall
// - reserved control bits read zero
// - per-flag interrupt enables plus global enable
// - enable bit gates all bus activity
// - stop interrupt enable lets stop set flag
// - promiscuous mode accepts every address
// - smart mode acts on data register read
// - ack action bit picks ack or nack
// - command codes complete, respond, none, reserved
// - complete or respond command write clears flags, reads zero
// - own address high seven bits, general call
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module tws_slave_top
  import tws_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // scl pin
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  // sda pin
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // interrupt
  input  wire logic        irq_global_enable,
  output logic             irq
);
  // register index of an address, IDX_NONE outside the window
  function automatic logic [7:0] idx_of(input logic [11:0] a);
    return (a[11:10] == 2'h0) ? a[9:2] : IDX_NONE;
  endfunction

  // true for an index that names a register
  function automatic logic mapped(input logic [7:0] i);
    return i == IDX_OWN_ADDR || i == IDX_STATUS || i == IDX_CTRL_B ||
           i == IDX_CTRL_A || i == IDX_DATA;
  endfunction

  tws_link_if lnk ();

  // line stage
  tws_line u_line (
    .aclk    (aclk),
    .aresetn (aresetn),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_oe  (sda_oe),
    .lnk     (lnk)
  );

  // axi slave state
  logic        aw_full_reg;   // write address held
  logic [11:0] awaddr_reg;    // held write address
  logic        w_full_reg;    // write data held
  logic [7:0]  wbyte_reg;     // held low data byte
  logic        wlane_reg;     // byte lane 0 enabled
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // software registers
  logic [7:0]  ctrl_a_reg;    // control a
  logic        ack_action_reg;
  logic [7:0]  own_addr_reg;  // own address, bit 0 general call
  logic [7:0]  data_reg, data_next;

  // engine state and status
  tws_state_t  state_reg, state_next;
  tws_after_t  after_reg, after_next;
  logic [3:0]  cnt_reg, cnt_next;       // bits seen in packet
  logic [7:0]  shift_reg, shift_next;   // packet shifter
  logic        ack_low_reg, ack_low_next;
  logic        df_reg, df_next;         // data flag
  logic        asf_reg, asf_next;       // address/stop flag
  logic        coll_reg, coll_next;     // collision flag
  logic        berr_reg, berr_next;     // bus error flag
  logic        dir_reg, dir_next;       // direction flag
  logic        as_reg, as_next;         // 1 address, 0 stop
  logic        rack_reg, rack_next;     // last ack from master
  logic        scl_oe_reg;
  logic        stretch_reg;   // flags a cycle ago, keeps scl low while sda settles
  logic        irq_reg;

  // axi handshakes and next values
  wire aw_acc       = s_axi_awvalid & awready_reg;
  wire w_acc        = s_axi_wvalid & wready_reg;
  wire wr_go        = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire aw_full_next = (aw_full_reg | aw_acc) & ~wr_go;
  wire w_full_next  = (w_full_reg | w_acc) & ~wr_go;
  wire bvalid_next  = wr_go | (bvalid_reg & ~s_axi_bready);
  wire ar_acc       = s_axi_arvalid & arready_reg;
  wire rvalid_next  = ar_acc | (rvalid_reg & ~s_axi_rready);

  // write decode
  wire [7:0] wr_idx  = idx_of(awaddr_reg);
  wire       wr_lane = wr_go & wlane_reg;
  wire       wr_own  = wr_lane & (wr_idx == IDX_OWN_ADDR);
  wire       wr_st   = wr_lane & (wr_idx == IDX_STATUS);
  wire       wr_cb   = wr_lane & (wr_idx == IDX_CTRL_B);
  wire       wr_ca   = wr_lane & (wr_idx == IDX_CTRL_A);
  wire       wr_dat  = wr_lane & (wr_idx == IDX_DATA);

  // read decode
  wire [7:0] rd_idx  = idx_of(s_axi_araddr);
  wire       rd_dat  = ar_acc & (rd_idx == IDX_DATA);

  // control fields
  wire en       = ctrl_a_reg[CA_EN];
  wire smart    = ctrl_a_reg[CA_SME];
  wire cmd_hi   = wr_cb & wbyte_reg[1];
  wire cmd_cpl  = wr_cb & (tws_cmd_t'(wbyte_reg[1:0]) == CMD_COMPLETE);
  wire aa_now   = wr_cb ? wbyte_reg[CB_AA] : ack_action_reg;

  // software events that release a held byte
  wire smart_rd = rd_dat & smart & (state_reg == ST_RX_HOLD);
  wire tx_load  = wr_dat & (state_reg == ST_TX_HOLD);
  wire flag_clr = wr_st & (wbyte_reg[SR_DF] | wbyte_reg[SR_ASF]);
  wire release_ev = cmd_hi | flag_clr | smart_rd | tx_load;
  wire go_on    = release_ev & ~cmd_cpl;

  // address match
  wire addr_hit = ctrl_a_reg[CA_PME] |
                  (shift_reg[7:1] == own_addr_reg[7:1]) |
                  (own_addr_reg[0] & (shift_reg[7:1] == 7'h00));

  // sda request to the line stage
  assign lnk.hold_ext = ctrl_a_reg[CA_HOLD];
  assign lnk.sda_want = en & (((state_reg == ST_ACK) & ack_low_reg) |
                        ((state_reg == ST_TX) & (cnt_reg < BYTE_BITS) & ~shift_reg[7]));

  // read data mux, reserved bits zero
  wire [7:0] status_w = {df_reg, asf_reg, scl_oe_reg, rack_reg,
                         coll_reg, berr_reg, dir_reg, as_reg};
  wire [7:0] rd_byte  = (rd_idx == IDX_OWN_ADDR) ? own_addr_reg :
                        (rd_idx == IDX_STATUS)   ? status_w :
                        (rd_idx == IDX_CTRL_B)   ? {5'h00, ack_action_reg, 2'h0} :
                        (rd_idx == IDX_CTRL_A)   ? ctrl_a_reg :
                        (rd_idx == IDX_DATA)     ? data_reg : 8'h00;

  // bit engine next state
  always_comb begin
    logic set_df;
    logic set_asf;
    logic set_coll;
    logic set_berr;
    set_df       = 1'b0;
    set_asf      = 1'b0;
    set_coll     = 1'b0;
    set_berr     = 1'b0;
    state_next   = state_reg;
    after_next   = after_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    ack_low_next = ack_low_reg;
    dir_next     = dir_reg;
    as_next      = as_reg;
    rack_next    = rack_reg;
    data_next    = wr_dat ? wbyte_reg : data_reg;
    coll_next    = coll_reg & ~(wr_st & wbyte_reg[SR_COLL]);
    if (!en) begin
      state_next = ST_IDLE;
    end else if (lnk.start_det) begin
      state_next = ST_ADDR;
      cnt_next   = 4'h0;
      coll_next  = 1'b0;
    end else if (lnk.stop_det) begin
      state_next = ST_IDLE;
      if (state_reg == ST_ADDR && cnt_reg == 4'h0) begin
        set_berr = 1'b1;
      end
      if (ctrl_a_reg[CA_SIE]) begin
        set_asf = 1'b1;
        as_next = 1'b0;
      end
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        // shift in address byte
        ST_ADDR: begin
          if (lnk.scl_rise) begin
            shift_next = {shift_reg[6:0], lnk.sda_lvl};
            cnt_next   = cnt_reg + 4'h1;
          end else if (lnk.scl_fall && cnt_reg == BYTE_BITS) begin
            if (addr_hit) begin
              set_asf    = 1'b1;
              as_next    = 1'b1;
              dir_next   = shift_reg[0];
              state_next = ST_ADDR_HOLD;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        // address held, waiting for software
        ST_ADDR_HOLD: begin
          if (cmd_cpl) begin
            ack_low_next = ~aa_now;
            after_next   = AFT_IDLE;
            state_next   = dir_reg ? ST_IDLE : ST_ACK;
            ack_low_next = ~aa_now & ~dir_reg;
          end else if (go_on) begin
            ack_low_next = ~aa_now;
            state_next   = ST_ACK;
            if (aa_now) begin
              after_next = AFT_IDLE;
            end else begin
              after_next = dir_reg ? AFT_TX : AFT_RX;
            end
          end
        end
        // acknowledge bit toward master
        ST_ACK: begin
          if (lnk.scl_rise && !ack_low_reg && !lnk.sda_lvl) begin
            set_coll   = 1'b1;
            state_next = ST_IDLE;
          end else if (lnk.scl_fall) begin
            cnt_next = 4'h0;
            unique case (after_reg)
              AFT_RX:  state_next = ST_RX;
              AFT_TX: begin
                set_df     = 1'b1;
                state_next = ST_TX_HOLD;
              end
              default: state_next = ST_IDLE;
            endcase
          end
        end
        // shift in data byte
        ST_RX: begin
          if (lnk.scl_rise) begin
            shift_next = {shift_reg[6:0], lnk.sda_lvl};
            cnt_next   = cnt_reg + 4'h1;
          end else if (lnk.scl_fall && cnt_reg == BYTE_BITS) begin
            data_next  = shift_reg;
            set_df     = 1'b1;
            state_next = ST_RX_HOLD;
          end
        end
        // received byte held, ack decision pending
        ST_RX_HOLD: begin
          if (cmd_cpl || go_on) begin
            ack_low_next = ~aa_now;
            state_next   = ST_ACK;
            after_next   = (aa_now || cmd_cpl) ? AFT_IDLE : AFT_RX;
          end
        end
        // waiting for transmit data
        ST_TX_HOLD: begin
          if (cmd_cpl) begin
            state_next = ST_IDLE;
          end else if (go_on) begin
            shift_next = tx_load ? wbyte_reg : data_reg;
            cnt_next   = 4'h0;
            state_next = ST_TX;
          end
        end
        // shift out byte, then sample master ack
        ST_TX: begin
          if (lnk.scl_rise) begin
            if (cnt_reg < BYTE_BITS && shift_reg[7] && !lnk.sda_lvl) begin
              set_coll   = 1'b1;
              state_next = ST_IDLE;
            end else begin
              if (cnt_reg == BYTE_BITS) begin
                rack_next = lnk.sda_lvl;
              end
              cnt_next = cnt_reg + 4'h1;
            end
          end else if (lnk.scl_fall) begin
            if (cnt_reg == ACK_BIT) begin
              set_df     = 1'b1;
              state_next = rack_reg ? ST_IDLE : ST_TX_HOLD;
            end else if (cnt_reg < BYTE_BITS) begin
              shift_next = {shift_reg[6:0], 1'b0};
            end
          end
        end
      endcase
    end
    // sticky flags, a set beats a clear
    df_next   = (df_reg & ~release_ev) | set_df;
    asf_next  = (asf_reg & ~release_ev) | set_asf;
    coll_next = coll_next | set_coll;
    berr_next = (berr_reg & ~(wr_st & wbyte_reg[SR_BERR])) | set_berr;
  end

  // axi channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg  <= ~w_full_next & ~bvalid_next;
      bvalid_reg  <= bvalid_next;
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
    end
  end

  // axi payload registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= 12'h000;
      wbyte_reg  <= RST_BYTE;
      wlane_reg  <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else begin
      if (aw_acc) awaddr_reg <= s_axi_awaddr;
      if (w_acc) begin
        wbyte_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
      if (wr_go) bresp_reg <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      if (ar_acc) begin
        rdata_reg <= {24'h000000, rd_byte};
        rresp_reg <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // software control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_reg     <= RST_BYTE;
      ack_action_reg <= 1'b0;
      own_addr_reg   <= RST_BYTE;
    end else begin
      if (wr_ca) ctrl_a_reg <= wbyte_reg & ~(8'h01 << CA_RSVD);
      if (wr_cb) ack_action_reg <= wbyte_reg[CB_AA];
      if (wr_own) own_addr_reg <= wbyte_reg;
    end
  end

  // engine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= ST_IDLE;
      after_reg   <= AFT_IDLE;
      cnt_reg     <= 4'h0;
      shift_reg   <= RST_BYTE;
      ack_low_reg <= 1'b0;
      data_reg    <= RST_BYTE;
      {df_reg, asf_reg, coll_reg, berr_reg} <= 4'h0;
      {dir_reg, as_reg, rack_reg}           <= 3'h0;
    end else begin
      state_reg   <= state_next;
      after_reg   <= after_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      ack_low_reg <= ack_low_next;
      data_reg    <= data_next;
      {df_reg, asf_reg, coll_reg, berr_reg} <= {df_next, asf_next, coll_next, berr_next};
      {dir_reg, as_reg, rack_reg}           <= {dir_next, as_next, rack_next};
    end
  end

  // clock stretch and interrupt request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_oe_reg <= 1'b0;
      stretch_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      // scl let go two cycles after the flags clear, so a new sda level is in place first
      stretch_reg <= df_reg | asf_reg;
      scl_oe_reg <= en & (df_reg | asf_reg | stretch_reg);
      irq_reg    <= irq_global_enable &
                    ((df_reg & ctrl_a_reg[CA_DIE]) | (asf_reg & ctrl_a_reg[CA_ASIE]));
    end
  end

  // outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign scl_oe        = scl_oe_reg;
  assign scl_out       = 1'b0;  // open drain, only ever pulls low
  assign sda_out       = 1'b0;
  assign irq           = irq_reg;
endmodule
`default_nettype wire

// *** tws_slave_monitor.sv ***
// tws_slave_monitor: port assertions for the two-wire slave
// assumes it is bound into tws_slave_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module tws_slave_monitor (
  // clock, reset, interrupt
  input wire logic        aclk, aresetn, irq_global_enable, irq,
  // register bus answers
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // bus pins
  input wire logic        scl_in, scl_out, scl_oe, sda_out, sda_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_W_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer stuck");
  AST_R_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("no read");
  AST_R_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer stuck");
  AST_R_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_OPEN_DRAIN: assert property (!scl_out && !sda_out) else $error("pin driven high");
  AST_IRQ_HOLD: assert property (irq |-> scl_oe) else $error("irq without clock hold");
  AST_IRQ_GATE: assert property (!irq_global_enable |=> !irq) else $error("irq ungated");
  AST_SDA_LOW: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved");
endmodule
bind tws_slave_top tws_slave_monitor u_mon (.aclk, .aresetn, .irq_global_enable, .irq,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe);
`default_nettype wire

// *** tws_bus_master.sv ***
// tws_bus_master: behavioural master on the open-drain lines
// assumes pulled-up lines resolved by the bench, 160 ns bit period
`timescale 1ns/100ps
`default_nettype none
module tws_bus_master (
  // resolved lines
  input  wire logic scl,
  input  wire logic sda,
  // line drives, 1 = released
  output var logic  scl_rel,
  output var logic  sda_rel
);
  initial begin scl_rel = 1'b1; sda_rel = 1'b1; end
  // one bit: data set while low, sampled late in the high phase
  task automatic bit1(input logic b, output logic s);
    #20 sda_rel = b;
    #60 scl_rel = 1'b1;
    wait (scl === 1'b1);
    #80 s = sda;
    scl_rel = 1'b0;
  endtask
  // eight bits, msb first
  task automatic send8(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
  endtask
  // start from an idle bus
  task automatic start();
    sda_rel = 1'b0;
    #80 scl_rel = 1'b0;
  endtask
  // stop from a low clock
  task automatic stop();
    #20 sda_rel = 1'b0;
    #60 scl_rel = 1'b1;
    wait (scl === 1'b1);
    #80 sda_rel = 1'b1;
    #160;
  endtask
  // start then stop with no bits between
  task automatic start_stop();
    sda_rel = 1'b0;
    #160 sda_rel = 1'b1;
    #160;
  endtask
endmodule
`default_nettype wire

// *** two_wire_slave_controller_tb_top.sv ***
// two_wire_slave_controller_tb_top: register and bus tests of the slave
// assumes tws_bus_master as far-side master, pull-ups on both lines
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module two_wire_slave_controller_tb_top;
  import tws_pkg::*;
  localparam logic [11:0] A_OWN = {2'h0, IDX_OWN_ADDR, 2'h0};
  localparam logic [11:0] A_ST = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] A_CB = {2'h0, IDX_CTRL_B, 2'h0};
  localparam logic [11:0] A_CA = {2'h0, IDX_CTRL_A, 2'h0};
  localparam logic [11:0] A_DT = {2'h0, IDX_DATA, 2'h0};
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} tws_row_t;
  // rows: address, write value, read back, response
  tws_row_t rows [4] = '{'{A_CA, 8'hFF, 8'hBF, RESP_OKAY}, '{A_CB, 8'hFF, 8'h04, RESP_OKAY},
    '{A_OWN, 8'hA5, 8'hA5, RESP_OKAY}, '{12'hFFC, 8'h5A, 8'h00, RESP_SLVERR}};
  logic aclk = 1'b0, aresetn = 1'b0, irq_global_enable = 1'b0, ack;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [7:0] q;
  logic [1:0] r;
  wire logic [3:0] s_axi_wstrb = 4'hF;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic scl_out, scl_oe, sda_out, sda_oe, irq, scl_rel, sda_rel;
  // wired-and lines with pull-ups
  wire logic scl_in = scl_rel & ~scl_oe;
  wire logic sda_in = sda_rel & ~sda_oe;
  int failures = 0, n_checks = 0;
  always #5 aclk = ~aclk;
  tws_slave_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
    .irq_global_enable, .irq);
  tws_bus_master mst (.scl(scl_in), .sda(sda_in), .scl_rel, .sda_rel);
  // one register access, answers sampled mid-cycle, released after the taking edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] qo, output logic [1:0] ro);
    logic ta, tw, dn;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_araddr <= a; s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= wr; s_axi_wvalid <= wr; s_axi_bready <= wr;
    s_axi_arvalid <= !wr; s_axi_rready <= !wr;
    do begin
      @(negedge aclk);
      ta = s_axi_awready & s_axi_awvalid | s_axi_arready & s_axi_arvalid;
      tw = s_axi_wready & s_axi_wvalid;
      dn = s_axi_bvalid | s_axi_rvalid;
      qo = s_axi_rdata[7:0]; ro = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) begin s_axi_awvalid <= 1'b0; s_axi_arvalid <= 1'b0; end
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!dn);
    s_axi_bready <= 1'b0; s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d); bus(1'b1, a, d, q, r); endtask
  // status with the master-ack and collision bits masked off
  task automatic st(input logic [7:0] e); #100 bus(1'b0, A_ST, 8'h00, q, r);
    `CHK(q & 8'hE7, e) endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin #300_000; failures++; wrap_up(); end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 8'h00, q, r);
      `CHK(q, 8'h00)
      `CHK(r, rows[i].r)
      wr(rows[i].a, rows[i].d);
      `CHK(r, rows[i].r)
      bus(1'b0, rows[i].a, 8'h00, q, r);
      `CHK(q, rows[i].e)
    end
    irq_global_enable <= 1'b1; wr(A_OWN, 8'hA0); wr(A_CA, 8'h19);
    mst.start(); mst.send8(8'hA0, q); st(8'h61);
    `CHK(irq, 1'b1)
    wr(A_CB, 8'h03); mst.bit1(1'b1, ack);
    `CHK(ack, 1'b0)
    mst.send8(8'h3C, q); st(8'hA1);
    wr(A_CB, 8'h04); bus(1'b0, A_DT, 8'h00, q, r);
    `CHK(q, 8'h3C)
    mst.bit1(1'b1, ack); mst.stop();
    `CHK(ack, 1'b1)
    irq_global_enable <= 1'b0; wr(A_CA, 8'h00);
    mst.start(); mst.send8(8'hA0, q); mst.bit1(1'b1, ack); mst.stop();
    `CHK(ack, 1'b1)
    irq_global_enable <= 1'b1; wr(A_CA, 8'h1A);
    mst.start(); mst.send8(8'hEF, q); st(8'h63);
    wr(A_CB, 8'h03); mst.bit1(1'b1, ack);
    `CHK(ack, 1'b0)
    st(8'hA3);
    wr(A_DT, 8'hC5); mst.send8(8'hFF, q); mst.bit1(1'b1, ack);
    `CHK(q, 8'hC5)
    st(8'hA3);
    wr(A_ST, 8'h80); mst.stop(); wr(A_CA, 8'h1E);
    mst.start_stop(); st(8'h66);
    `CHK(q[2], 1'b1)
    wrap_up();
  end
endmodule
`default_nettype wire
